/* nsled_board.sv */
/* LED board model: turns driver pins into lit flags.
   Assumes the seven pins ending in _N sink the LED current. */
`timescale 1ns/1ps
module nsled_board (
	input  wire [10:0] drv,
	output wire [10:0] lit
);
	assign lit = {~drv[10:4], drv[3:0]};
endmodule

/* nsled_chk.sv */
/* Checker for nsled_driver, bound to every instance.
   Assumes registers change only through bus write strobes. */
`timescale 1ns/1ps
module nsled_chk #(parameter BLINK_CYCLES = 4) (
	input wire CLOCK, RESETN, POR_N, WR, RD, WDT_INT_ERR, WDT_EXT_ERR,
	input wire [3:0] ADDR,
	input wire [7:0] WDATA,
	input wire PORT_A_TX, PORT_A_RX, PORT_B_TX, PORT_B_RX, PORT_A_LINK,
	input wire PORT_A_ABNORMAL, PORT_A_LOOPBACK, LINK_ESTABLISHED,
	input wire CYCLIC_RUNNING, RUN_INDICATOR_N, TX_OR_PORT1_ACTIVITY_N,
	input wire RX_OR_PORT2_ACTIVITY_N, DATALINK_INDICATOR_N,
	input wire STATION_ERROR_INDICATOR_N, PORT_A_LINE_ERROR_N,
	input wire USER_INDICATOR_ONE, USER_INDICATOR_TWO, PORT_A_LINK_INDICATOR
);
	reg [4:0] ctrl_r;
	reg [6:0] sw_r;
	reg       wdt_r;
	wire act1 = ctrl_r[0] ? PORT_A_TX | PORT_A_RX : PORT_A_TX | PORT_B_TX;
	wire act2 = ctrl_r[0] ? PORT_B_TX | PORT_B_RX : PORT_A_RX | PORT_B_RX;
	wire lerr = ctrl_r[4] ? sw_r[3] : PORT_A_ABNORMAL | PORT_A_LOOPBACK;
	wire off_n = RUN_INDICATOR_N & DATALINK_INDICATOR_N & PORT_A_LINE_ERROR_N;
	wire ok = POR_N && !wdt_r;
	// Watchdog seen early on purpose: its sync delay is not modelled
	always @(posedge CLOCK) begin
		if (!RESETN) begin
			ctrl_r <= 5'h00;
			sw_r <= 7'h00;
			wdt_r <= 1'b0;
		end else begin
			if (WR && ADDR == 4'h0) ctrl_r <= WDATA[4:0];
			if (WR && ADDR == 4'h1) sw_r <= WDATA[6:0];
			if (WDT_INT_ERR | WDT_EXT_ERR) wdt_r <= 1'b1;
		end
	end
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RESETN);
	por_off_a: assert property (disable iff (1'b0)
		!POR_N |=> off_n && TX_OR_PORT1_ACTIVITY_N && !USER_INDICATOR_ONE)
		else $error("indicator lit in power-on reset");
	sys_reset_a: assert property (disable iff (1'b0)
		!RESETN && POR_N |=> off_n && STATION_ERROR_INDICATOR_N
		&& !USER_INDICATOR_ONE && !PORT_A_LINK_INDICATOR)
		else $error("indicator lit in system reset");
	wdt_err_a: assert property (POR_N
		&& (WDT_INT_ERR | WDT_EXT_ERR) |-> ##[1:6]
		!STATION_ERROR_INDICATOR_N && off_n && !USER_INDICATOR_ONE)
		else $error("watchdog pattern missing");
	act_first_a: assert property (POR_N |=>
		TX_OR_PORT1_ACTIVITY_N == !$past(act1))
		else $error("first activity wrong");
	act_second_a: assert property (POR_N |=>
		RX_OR_PORT2_ACTIVITY_N == !$past(act2))
		else $error("second activity wrong");
	user_sw_a: assert property (ok && $past(POR_N) |=>
		USER_INDICATOR_ONE == $past(sw_r[5])
		&& USER_INDICATOR_TWO == $past(sw_r[6]))
		else $error("user indicator wrong");
	line_err_a: assert property (ok && $past(POR_N) |=>
		PORT_A_LINE_ERROR_N == !$past(lerr))
		else $error("line error wrong");
	dlink_hw_a: assert property (ok && $past(POR_N) && !ctrl_r[2]
		&& LINK_ESTABLISHED == CYCLIC_RUNNING
		|=> DATALINK_INDICATOR_N == !$past(LINK_ESTABLISHED))
		else $error("data-link wrong");
	link_ind_a: assert property (POR_N && $past(POR_N) && RESETN |=>
		PORT_A_LINK_INDICATOR == $past(PORT_A_LINK))
		else $error("link indicator wrong");
	cover property (WDT_INT_ERR ##6 !STATION_ERROR_INDICATOR_N);
	cover property (ctrl_r[0] && !TX_OR_PORT1_ACTIVITY_N);
	cover property ($fell(DATALINK_INDICATOR_N) && !CYCLIC_RUNNING);
endmodule
bind nsled_driver nsled_chk #(.BLINK_CYCLES(BLINK_CYCLES)) nsled_chk_inst (.*);

/* nsled_driver.v */
/*
 * Network status LED driver: run, activity, data-link, error, user,
 * port link and port line-error indicator outputs.
 * Assumes status inputs from the link logic are synchronous to CLOCK,
 * except the watchdog pins, which arrive asynchronously.
 */
`timescale 1ns/1ps
`include "nsled_regs.vh"

module nsled_driver #(
	parameter BLINK_CYCLES = `NSLED_BLINK_MS * `NSLED_CLK_KHZ
) (
	input  wire       CLOCK,
	input  wire       RESETN,
	input  wire       POR_N,
	input  wire [3:0] ADDR,
	input  wire [7:0] WDATA,
	input  wire       WR,
	input  wire       RD,
	output reg  [7:0] RDATA,
	input  wire       STATION_OK,
	input  wire       STATION_ERROR,
	input  wire       LINK_ESTABLISHED,
	input  wire       CYCLIC_RUNNING,
	input  wire       WDT_INT_ERR,
	input  wire       WDT_EXT_ERR,
	input  wire       PORT_A_TX,
	input  wire       PORT_A_RX,
	input  wire       PORT_B_TX,
	input  wire       PORT_B_RX,
	input  wire       PORT_A_LINK,
	input  wire       PORT_B_LINK,
	input  wire       PORT_A_ABNORMAL,
	input  wire       PORT_B_ABNORMAL,
	input  wire       PORT_A_LOOPBACK,
	input  wire       PORT_B_LOOPBACK,
	output reg        RUN_INDICATOR_N,
	output reg        TX_OR_PORT1_ACTIVITY_N,
	output reg        RX_OR_PORT2_ACTIVITY_N,
	output reg        DATALINK_INDICATOR_N,
	output reg        STATION_ERROR_INDICATOR_N,
	output reg        PORT_A_LINE_ERROR_N,
	output reg        PORT_B_LINE_ERROR_N,
	output reg        USER_INDICATOR_ONE,
	output reg        USER_INDICATOR_TWO,
	output reg        PORT_A_LINK_INDICATOR,
	output reg        PORT_B_LINK_INDICATOR
);

	// -----------------------------------------------------------------
	// Registers
	// -----------------------------------------------------------------
	reg [4:0]  ctrl_r;
	reg [6:0]  swled_r;
	reg [2:0]  wdi_sync_r;
	reg [2:0]  wde_sync_r;
	reg        wdi_r;
	reg        wde_r;
	reg        wdt_err_r;
	reg [31:0] blink_cnt_r;
	reg        blink_r;
	reg        por_done_r;

	wire mode_per_port = ctrl_r[`NSLED_CTRL_MODE];

	// Three-stage sync; level changes once stages two and three agree
	always @(posedge CLOCK) begin
		if (!RESETN) begin
			wdi_sync_r <= 3'h0;
			wde_sync_r <= 3'h0;
			wdi_r      <= 1'b0;
			wde_r      <= 1'b0;
		end else begin
			wdi_sync_r <= {wdi_sync_r[1:0], WDT_INT_ERR};
			wde_sync_r <= {wde_sync_r[1:0], WDT_EXT_ERR};
			if (wdi_sync_r[1] == wdi_sync_r[2])
				wdi_r <= wdi_sync_r[2];
			if (wde_sync_r[1] == wde_sync_r[2])
				wde_r <= wde_sync_r[2];
		end
	end

	// -----------------------------------------------------------------
	// Register port
	// -----------------------------------------------------------------
	// Watchdog error latches; only a reset clears it, so software
	// cannot relight run before the station is restarted
	always @(posedge CLOCK) begin
		if (!RESETN) begin
			ctrl_r    <= `NSLED_CTRL_RST;
			swled_r   <= `NSLED_SWLED_RST;
			wdt_err_r <= 1'b0;
			RDATA     <= 8'h00;
		end else begin
			if (wdi_r || wde_r)
				wdt_err_r <= 1'b1;
			if (WR && ADDR == `NSLED_OFF_CTRL)
				ctrl_r <= WDATA[4:0];
			if (WR && ADDR == `NSLED_OFF_SWLED)
				swled_r <= WDATA[6:0];
			RDATA <= 8'h00;
			if (RD) begin
				case (ADDR)
				`NSLED_OFF_CTRL:   RDATA <= {3'h0, ctrl_r};
				`NSLED_OFF_SWLED:  RDATA <= {1'b0, swled_r};
				`NSLED_OFF_STATUS: RDATA <= {3'h0, wdt_err_r,
					LINK_ESTABLISHED, CYCLIC_RUNNING,
					PORT_A_LINK, PORT_B_LINK};
				default:           RDATA <= 8'h00;
				endcase
			end
		end
	end

	// -----------------------------------------------------------------
	// Data-link blink timer
	// -----------------------------------------------------------------
	always @(posedge CLOCK) begin
		if (!RESETN) begin
			blink_cnt_r <= 32'h0;
			blink_r     <= 1'b0;
		end else if (blink_cnt_r >= BLINK_CYCLES - 1) begin
			blink_cnt_r <= 32'h0;
			blink_r     <= ~blink_r;
		end else begin
			blink_cnt_r <= blink_cnt_r + 32'h1;
		end
	end

	// -----------------------------------------------------------------
	// Indicator logic (lit levels, before polarity)
	// -----------------------------------------------------------------
	reg hw_dlink;
	reg lit_run;
	reg lit_dlink;
	reg lit_err;
	reg lit_la;
	reg lit_lb;
	reg lit_act1;
	reg lit_act2;
	always @* begin
		hw_dlink = 1'b0;
		if (LINK_ESTABLISHED)
			hw_dlink = CYCLIC_RUNNING ? 1'b1 : blink_r;
		lit_run   = ctrl_r[`NSLED_CTRL_SW_RUN] ?
			swled_r[`NSLED_SW_RUN] : STATION_OK;
		lit_dlink = ctrl_r[`NSLED_CTRL_SW_DLINK] ?
			swled_r[`NSLED_SW_DLINK] : hw_dlink;
		lit_err   = ctrl_r[`NSLED_CTRL_SW_ERR] ?
			swled_r[`NSLED_SW_ERR] : STATION_ERROR;
		lit_la    = ctrl_r[`NSLED_CTRL_SW_LERR] ? swled_r[`NSLED_SW_LERR_A]
			: (PORT_A_ABNORMAL | PORT_A_LOOPBACK);
		lit_lb    = ctrl_r[`NSLED_CTRL_SW_LERR] ? swled_r[`NSLED_SW_LERR_B]
			: (PORT_B_ABNORMAL | PORT_B_LOOPBACK);
		if (mode_per_port) begin
			lit_act1 = PORT_A_TX | PORT_A_RX;
			lit_act2 = PORT_B_TX | PORT_B_RX;
		end else begin
			lit_act1 = PORT_A_TX | PORT_B_TX;
			lit_act2 = PORT_A_RX | PORT_B_RX;
		end
	end

	// -----------------------------------------------------------------
	// Output flops
	// -----------------------------------------------------------------
	// POR_N is the power-on reset; RESETN is system reset, which
	// leaves the activity outputs alone once power-on has completed
	always @(posedge CLOCK) begin
		if (!POR_N) begin
			por_done_r             <= 1'b0;
			TX_OR_PORT1_ACTIVITY_N <= 1'b1;
			RX_OR_PORT2_ACTIVITY_N <= 1'b1;
		end else begin
			por_done_r             <= 1'b1;
			TX_OR_PORT1_ACTIVITY_N <= ~lit_act1;
			RX_OR_PORT2_ACTIVITY_N <= ~lit_act2;
		end
	end

	always @(posedge CLOCK) begin
		if (!POR_N || !RESETN || !por_done_r) begin
			RUN_INDICATOR_N           <= 1'b1;
			DATALINK_INDICATOR_N      <= 1'b1;
			STATION_ERROR_INDICATOR_N <= 1'b1;
			PORT_A_LINE_ERROR_N       <= 1'b1;
			PORT_B_LINE_ERROR_N       <= 1'b1;
			USER_INDICATOR_ONE        <= 1'b0;
			USER_INDICATOR_TWO        <= 1'b0;
			PORT_A_LINK_INDICATOR     <= 1'b0;
			PORT_B_LINK_INDICATOR     <= 1'b0;
		end else begin
			PORT_A_LINK_INDICATOR <= PORT_A_LINK;
			PORT_B_LINK_INDICATOR <= PORT_B_LINK;
			if (wdt_err_r) begin
				RUN_INDICATOR_N           <= 1'b1;
				DATALINK_INDICATOR_N      <= 1'b1;
				STATION_ERROR_INDICATOR_N <= 1'b0;
				PORT_A_LINE_ERROR_N       <= 1'b1;
				PORT_B_LINE_ERROR_N       <= 1'b1;
				USER_INDICATOR_ONE        <= 1'b0;
				USER_INDICATOR_TWO        <= 1'b0;
			end else begin
				RUN_INDICATOR_N           <= ~lit_run;
				DATALINK_INDICATOR_N      <= ~lit_dlink;
				STATION_ERROR_INDICATOR_N <= ~lit_err;
				PORT_A_LINE_ERROR_N       <= ~lit_la;
				PORT_B_LINE_ERROR_N       <= ~lit_lb;
				USER_INDICATOR_ONE        <= swled_r[`NSLED_SW_USER1];
				USER_INDICATOR_TWO        <= swled_r[`NSLED_SW_USER2];
			end
		end
	end

endmodule

/* nsled_regs.vh */
/*
 * Constants of the network status LED driver: register offsets, field
 * positions, reset values and timing counts.
 * Assumes inclusion by bare name from the driver module only.
 */
`ifndef NSLED_REGS_VH
`define NSLED_REGS_VH

// ---------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------
`define NSLED_OFF_CTRL      4'h0
`define NSLED_OFF_SWLED     4'h1
`define NSLED_OFF_STATUS    4'h2

// ---------------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------------
`define NSLED_CTRL_MODE     0
`define NSLED_CTRL_SW_RUN   1
`define NSLED_CTRL_SW_DLINK 2
`define NSLED_CTRL_SW_ERR   3
`define NSLED_CTRL_SW_LERR  4
`define NSLED_CTRL_RST      5'h00

// ---------------------------------------------------------------------
// Software LED register fields
// ---------------------------------------------------------------------
`define NSLED_SW_RUN        0
`define NSLED_SW_DLINK      1
`define NSLED_SW_ERR        2
`define NSLED_SW_LERR_A     3
`define NSLED_SW_LERR_B     4
`define NSLED_SW_USER1      5
`define NSLED_SW_USER2      6
`define NSLED_SWLED_RST     7'h00

// ---------------------------------------------------------------------
// Timing: data-link blink half period
// ---------------------------------------------------------------------
`define NSLED_BLINK_MS      250
`define NSLED_CLK_KHZ       10000

`endif

/* nsled_tb.sv */
/* Self-checking bench for nsled_driver with a board model on its pins.
   Assumes a blink count of 4 so blinking shows within a few cycles. */
`timescale 1ns/1ps
module testbench;
	logic CLOCK = 0, RESETN = 0, POR_N = 0, WR = 0, RD = 0;
	logic [3:0] ADDR = 4'h0;
	logic [7:0] WDATA = 8'h00;
	logic STATION_OK = 0, STATION_ERROR = 0, LINK_ESTABLISHED = 0;
	logic CYCLIC_RUNNING = 0, WDT_INT_ERR = 0, WDT_EXT_ERR = 0;
	logic PORT_A_TX = 0, PORT_A_RX = 0, PORT_B_TX = 0, PORT_B_RX = 0;
	logic PORT_A_LINK = 0, PORT_B_LINK = 0, PORT_A_ABNORMAL = 0;
	logic PORT_B_ABNORMAL = 0, PORT_A_LOOPBACK = 0, PORT_B_LOOPBACK = 0;
	wire [7:0]  RDATA;
	wire [10:0] drv, lit;
	int miscompares = 0, num_checks = 0, cyc = 0;
	nsled_board nsled_board_inst (.drv(drv), .lit(lit));
	nsled_driver #(.BLINK_CYCLES(4)) nsled_driver_inst (.*,
		.RUN_INDICATOR_N(drv[10]), .TX_OR_PORT1_ACTIVITY_N(drv[9]),
		.RX_OR_PORT2_ACTIVITY_N(drv[8]), .DATALINK_INDICATOR_N(drv[7]),
		.STATION_ERROR_INDICATOR_N(drv[6]), .PORT_A_LINE_ERROR_N(drv[5]),
		.PORT_B_LINE_ERROR_N(drv[4]), .USER_INDICATOR_ONE(drv[3]),
		.USER_INDICATOR_TWO(drv[2]), .PORT_A_LINK_INDICATOR(drv[1]),
		.PORT_B_LINK_INDICATOR(drv[0]));
	initial forever #50 CLOCK = ~CLOCK;
	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge CLOCK) begin
		cyc++;
		if (cyc == 2000) begin
			miscompares++;
			end_of_test;
		end
	end
	task chk(input string n, input logic [10:0] s, e);
		num_checks++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch %s exp %h seen %h", n, e, s);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge CLOCK);
		#1;
	endtask
	task led(input logic [10:0] m, e);
		tick(3);
		chk("leds", lit & m, e);
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge CLOCK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1;
		@(posedge CLOCK);
		WR <= 0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge CLOCK);
		ADDR <= a;
		RD <= 1;
		@(posedge CLOCK);
		RD <= 0;
		#1 chk("rdata", {3'h0, RDATA}, {3'h0, e});
	endtask
	// Run is masked until s_hw drives its station-state source
	task s_act;
		led(11'h3ff, 11'h202);
		@(posedge CLOCK);
		PORT_A_TX <= 0;
		PORT_A_RX <= 1;
		led(11'h3ff, 11'h102);
		wr(4'h0, 8'h01);
		led(11'h3ff, 11'h202);
		@(posedge CLOCK);
		PORT_A_RX <= 0;
		PORT_B_TX <= 1;
		led(11'h3ff, 11'h102);
		wr(4'h0, 8'h00);
		led(11'h3ff, 11'h202);
	endtask
	task s_hw;
		int on, off;
		@(posedge CLOCK);
		PORT_B_TX <= 0;
		LINK_ESTABLISHED <= 1;
		CYCLIC_RUNNING <= 1;
		PORT_A_LOOPBACK <= 1;
		led(11'h3ff, 11'h0a2);
		@(posedge CLOCK);
		CYCLIC_RUNNING <= 0;
		on = 0;
		off = 0;
		repeat (12) begin
			tick(1);
			if (lit[7]) on++;
			else off++;
		end
		chk("blink", {9'h0, on > 0, off > 0}, 11'h003);
		@(posedge CLOCK);
		LINK_ESTABLISHED <= 0;
		PORT_A_LOOPBACK <= 0;
		PORT_A_ABNORMAL <= 1;
		PORT_B_LOOPBACK <= 1;
		led(11'h3ff, 11'h032);
		@(posedge CLOCK);
		PORT_A_ABNORMAL <= 0;
		PORT_B_LOOPBACK <= 0;
		PORT_A_LINK <= 0;
		led(11'h3ff, 11'h000);
		@(posedge CLOCK);
		STATION_OK <= 1;
		led(11'h7ff, 11'h400);
		@(posedge CLOCK);
		STATION_OK <= 0;
		STATION_ERROR <= 1;
		led(11'h7ff, 11'h040);
	endtask
	task s_sw;
		@(posedge CLOCK);
		PORT_B_ABNORMAL <= 1;
		PORT_A_LINK <= 1;
		wr(4'h0, 8'h1e);
		wr(4'h1, 8'h6b);
		led(11'h7ff, 11'h4ae);
		rd(4'h0, 8'h1e);
		rd(4'h1, 8'h6b);
		rd(4'h2, 8'h02);
		rd(4'h7, 8'h00);
	endtask
	task s_rst;
		@(posedge CLOCK);
		PORT_A_TX <= 1;
		PORT_B_LINK <= 1;
		STATION_ERROR <= 0;
		RESETN <= 0;
		led(11'h7ff, 11'h200);
		@(posedge CLOCK);
		RESETN <= 1;
		WDT_INT_ERR <= 1;
		tick(5);
		led(11'h7ff, 11'h243);
		rd(4'h2, 8'h13);
		@(posedge CLOCK);
		WDT_INT_ERR <= 0;
		RESETN <= 0;
		led(11'h7ff, 11'h200);
		@(posedge CLOCK);
		RESETN <= 1;
		WDT_EXT_ERR <= 1;
		rd(4'h2, 8'h03);
		tick(2);
		led(11'h7ff, 11'h243);
	endtask
	initial begin
		@(posedge CLOCK);
		PORT_A_TX <= 1;
		PORT_A_LINK <= 1;
		tick(18);
		chk("leds", lit, 11'h000);
		@(posedge CLOCK);
		RESETN <= 1;
		POR_N <= 1;
		s_act;
		s_hw;
		s_sw;
		s_rst;
		end_of_test;
	end
endmodule
